// ### hw/leadoff_pace_measure_readback.v
`timescale 1ns/1ns
`include "leadoff_pace_map.vh"
module leadoff_pace_measure_readback #(
    parameter HAS_PACE          = 1,
    parameter AMP_UPDATE_CYCLES = `AMP_UPDATE_CYCLES,
    parameter AVG_SHIFT         = `AVG_SHIFT
) (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg         pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // band-pass filtered 2 kHz electrode samples, signed
    input  wire        bp_valid,
    input  wire [15:0] bp_left_arm,
    input  wire [15:0] bp_left_leg,
    input  wire [15:0] bp_right_arm,
    // qualified pace pulse reports
    input  wire [2:0]  pace_done,
    input  wire [47:0] pace_height,
    input  wire [23:0] pace_width,
    // control mirrored out
    output reg         ac_leadoff_sel,
    output reg         pace_width_filter_en
);
    reg  [15:0] amp_q [0:2];
    reg  [23:0] pace_q [0:2];
    reg  [31:0] tick_cnt_q;
    reg  [1:0]  ctrl_q;
    wire [15:0] avg [0:2];
    wire [47:0] bp_bus;
    wire        tick;
    wire        setup;

    assign bp_bus = {bp_right_arm, bp_left_leg, bp_left_arm};
    assign tick   = (tick_cnt_q == AMP_UPDATE_CYCLES - 1);
    assign setup  = psel && !penable;

    // returns the register index for a byte address, or ff when misaligned or above bit 9
    function [7:0] word_index;
        input [31:0] a;
        begin
            if (a[1:0] != 2'b00 || a[31:10] != 22'h0)
                word_index = 8'hFF;
            else
                word_index = a[9:2];
        end
    endfunction

    // averaged output is already 2/pi times the peak: rectified-sine mean
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ch
            rectify_average #(.SHIFT(AVG_SHIFT)) u_avg (
                .pclk      (pclk),
                .presetn   (presetn),
                .smp_valid (bp_valid && ctrl_q[`CTRL_AC_SEL_BIT]),
                .smp_data  (bp_bus[16*g +: 16]),
                .avg       (avg[g])
            );

            // snapshot refreshes only at the 8 Hz tick, and only while the ac select control bit is set
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    amp_q[g] <= 16'h0000;
                end else if (tick && ctrl_q[`CTRL_AC_SEL_BIT]) begin
                    amp_q[g] <= avg[g];
                end
            end

            // width floor applied only while filter on
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pace_q[g] <= `MEAS_RESET;
                end else if (HAS_PACE != 0 && pace_done[g]) begin
                    if (!ctrl_q[`CTRL_WIDTH_FILT_BIT] ||
                        pace_width[8*g +: 8] >= `PACE_MIN_WIDTH) begin
                        pace_q[g] <= {pace_height[16*g +: 16],
                                      pace_width[8*g +: 8]};
                    end
                end
            end
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h00000000;
        end else if (tick) begin
            tick_cnt_q <= 32'h00000000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
        end
    end

    // read mux
    reg [31:0] rd_d;
    reg        err_d;
    reg [7:0]  idx;
    always @* begin
        idx   = word_index(paddr);
        rd_d  = 32'h00000000;
        err_d = 1'b0;
        case (idx)
            `IDX_LEFT_ARM_AMP:  rd_d = {idx, 8'h00, amp_q[0]};
            `IDX_LEFT_LEG_AMP:  rd_d = {idx, 8'h00, amp_q[1]};
            `IDX_RIGHT_ARM_AMP: rd_d = {idx, 8'h00, amp_q[2]};
            `IDX_PACE_LEAD1: begin
                rd_d  = {idx, pace_q[0]};
                err_d = (HAS_PACE == 0);
            end
            `IDX_PACE_LEAD2: begin
                rd_d  = {idx, pace_q[1]};
                err_d = (HAS_PACE == 0);
            end
            `IDX_PACE_LEAD3: begin
                rd_d  = {idx, pace_q[2]};
                err_d = (HAS_PACE == 0);
            end
            `IDX_MEAS_CTRL:   rd_d = {idx, 22'h0, ctrl_q};
            `IDX_MEAS_STATUS: rd_d = {idx, 21'h0, pace_q[2] != 24'h0,
                                      pace_q[1] != 24'h0, pace_q[0] != 24'h0};
            default:          err_d = 1'b1;
        endcase
        if (err_d) begin
            rd_d = 32'h00000000;
        end
    end

    // no wait state: answer registered in setup, ready in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            ctrl_q  <= `CTRL_RESET;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata  <= pwrite ? 32'h00000000 : rd_d;
                // only control is writable; measurement writes are errors
                pslverr <= err_d || (pwrite && idx != `IDX_MEAS_CTRL);
            end else begin
                pslverr <= 1'b0;
            end
            if (psel && penable && pready && pwrite && idx == `IDX_MEAS_CTRL) begin
                ctrl_q <= pwdata[1:0];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ac_leadoff_sel       <= 1'b1;
            pace_width_filter_en <= 1'b1;
        end else begin
            ac_leadoff_sel       <= ctrl_q[`CTRL_AC_SEL_BIT];
            pace_width_filter_en <= ctrl_q[`CTRL_WIDTH_FILT_BIT];
        end
    end
endmodule // leadoff_pace_measure_readback

// ### hw/leadoff_pace_map.vh
`ifndef LEADOFF_PACE_MAP_VH
`define LEADOFF_PACE_MAP_VH

// register word indices (byte address = index * 4)
`define IDX_LEFT_ARM_AMP      8'h31
`define IDX_LEFT_LEG_AMP      8'h32
`define IDX_RIGHT_ARM_AMP     8'h33
`define IDX_PACE_LEAD1        8'h3A
`define IDX_PACE_LEAD2        8'h3B
`define IDX_PACE_LEAD3        8'h3C
`define IDX_MEAS_CTRL         8'h40
`define IDX_MEAS_STATUS       8'h41

// field positions
`define AMP_MSB               15
`define PACE_HEIGHT_MSB       23
`define PACE_HEIGHT_LSB       8
`define PACE_WIDTH_MSB        7
`define ADDR_FIELD_LSB        24
`define CTRL_AC_SEL_BIT       0
`define CTRL_WIDTH_FILT_BIT   1

// reset values
`define MEAS_RESET            24'h000000
`define CTRL_RESET            2'h3

// timing
`define CLK_HZ                100000000
`define AMP_UPDATE_HZ         8
`define AMP_UPDATE_CYCLES     (`CLK_HZ / `AMP_UPDATE_HZ)
`define AVG_SHIFT             4
`define PACE_MIN_WIDTH        8'h0C

`endif

// ### hw/rectify_average.v
`timescale 1ns/1ns
// rectifies band-pass samples and low-pass averages them (single pole iir)
module rectify_average #(
    parameter SHIFT = 4
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // sample stream
    input  wire        smp_valid,
    input  wire [15:0] smp_data,
    // averaged magnitude
    output wire [15:0] avg
);
    reg  [15:0] acc_q;
    wire [15:0] mag;
    wire [16:0] next_acc;

    // abs of signed sample; most negative saturates
    assign mag = smp_data[15] ? ((smp_data == 16'h8000) ? 16'h7FFF
                                 : (~smp_data + 16'h0001)) : smp_data;
    assign next_acc = {1'b0, acc_q} + {1'b0, mag >> SHIFT} - {1'b0, acc_q >> SHIFT};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 16'h0000;
        end else if (smp_valid) begin
            acc_q <= next_acc[15:0];
        end
    end

    assign avg = acc_q;
endmodule // rectify_average

// ### testbench/leadoff_props.sv
`timescale 1ns/1ns
module leadoff_props (
    // apb side of the bank
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [7:0] idx   = paddr[9:2];
    wire       rd_ok = pready && !pwrite && !pslverr;
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_idle: assert property (!psel |=> !pready)
        else $error("ready without select");
    a_index_echo: assert property (rd_ok |-> prdata[31:24] == idx)
        else $error("index byte wrong");
    a_amp_reserved: assert property (rd_ok && idx >= 8'h31 && idx <= 8'h33 |->
        prdata[23:16] == 8'h00) else $error("reserved bits set");
    a_write_refused: assert property (pready && pwrite && idx != 8'h40 |-> pslverr)
        else $error("write to measurement taken");
    a_pace_present: assert property (pready && idx >= 8'h3A && idx <= 8'h3C &&
        !pwrite |-> !pslverr) else $error("pace register missing");
    a_err_blank: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error read carries data");
    c_read: cover property (rd_ok);
    c_refused: cover property (pready && pslverr);
    c_write: cover property (pready && pwrite && !pslverr);
endmodule // leadoff_props
bind leadoff_pace_measure_readback leadoff_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));

// ### testbench/apb_host_model.sv
`timescale 1ns/1ns
module apb_host_model (
    // clock and answer
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    // request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      paddr,
    output logic [31:0]      pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // measurements are only reachable by explicit reads, one per register
    task xfer(input logic w, input logic [7:0] i, input logic [31:0] wd,
              output logic [31:0] rd, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, i, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: pready or else the bench timeout ends this wait
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // apb_host_model

// ### testbench/leadoff_pace_measure_readback_tb_top.sv
`timescale 1ns/1ns
module leadoff_pace_measure_readback_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        bp_valid, a_sel, f_en;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] bp_left_arm, bp_left_leg, bp_right_arm;
    logic [2:0]  pace_done;
    logic [47:0] pace_height;
    logic [23:0] pace_width;
    logic [7:0]  regs [6] = '{8'h31, 8'h32, 8'h33, 8'h3A, 8'h3B, 8'h3C};
    int          err_total, n_checks, cyc;
    // short refresh period keeps the run brief
    leadoff_pace_measure_readback #(.AMP_UPDATE_CYCLES(16)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .bp_valid(bp_valid), .bp_left_arm(bp_left_arm), .bp_left_leg(bp_left_leg),
        .bp_right_arm(bp_right_arm),
        .pace_done(pace_done), .pace_height(pace_height), .pace_width(pace_width),
        .ac_leadoff_sel(a_sel), .pace_width_filter_en(f_en));
    apb_host_model host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // 33 bits so the error flag rides above a full read word
    task check(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task rd_chk(input logic [7:0] i, input logic [31:0] x);
        host.xfer(1'b0, i, 32'h0, rd, e);
        check({e, rd}, {1'b0, x});
    endtask
    task pace(input int g, input logic [15:0] h, input logic [7:0] w);
        @(posedge pclk);
        pace_done <= 3'b001 << g;
        pace_height[g*16 +: 16] <= h;
        pace_width[g*8 +: 8] <= w;
        @(posedge pclk);
        pace_done <= 3'b000;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            results;
        end
    end
    initial begin
        {presetn, bp_valid, bp_left_arm, bp_left_leg, bp_right_arm} = '0;
        {pace_done, pace_height, pace_width} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 6; k++) rd_chk(regs[k], {regs[k], 24'h0});
        check({a_sel, f_en}, 2'b11);
        host.xfer(1'b1, 8'h31, 32'hFFFF, rd, e);
        check(e, 1'b1);
        rd_chk(8'h31, 32'h3100_0000);
        host.xfer(1'b0, 8'h3D, 32'h0, rd, e);
        check(e, 1'b1);
        for (int k = 0; k < 3; k++) begin
            pace(k, 16'h8001 + 16'(k), 8'hFF - 8'(k));
            rd_chk(8'h3A + 8'(k), {8'h3A + 8'(k), 16'h8001 + 16'(k), 8'hFF - 8'(k)});
        end
        pace(0, 16'h0123, 8'h0B);
        rd_chk(8'h3A, 32'h3A80_01FF);
        pace(1, 16'h0456, 8'h0C);
        rd_chk(8'h3B, 32'h3B04_560C);
        host.xfer(1'b1, 8'h40, 32'h1, rd, e);
        repeat (3) @(posedge pclk);
        check({e, f_en, a_sel}, 3'b001);
        pace(0, 16'hFFFE, 8'h00);
        rd_chk(8'h3A, 32'h3AFF_FE00);
        // constant levels, bp_valid every clock; rectified average settles near the magnitude
        bp_left_arm <= 16'hFC18;
        bp_left_leg <= 16'h01F4;
        bp_valid <= 1'b1;
        repeat (400) @(posedge pclk);
        host.xfer(1'b0, 8'h31, 32'h0, rd, e);
        check(rd[15:0] >= 16'd984 && rd[15:0] <= 16'd1000, 1'b1);
        host.xfer(1'b0, 8'h32, 32'h0, rd, e);
        check(rd[15:0] >= 16'd484 && rd[15:0] <= 16'd500, 1'b1);
        rd_chk(8'h33, 32'h3300_0000);
        host.xfer(1'b1, 8'h40, 32'h0, rd, e);
        bp_left_arm <= 16'h0000;
        repeat (200) @(posedge pclk);
        host.xfer(1'b0, 8'h31, 32'h0, rd, e);
        check(rd[15:0] >= 16'd984, 1'b1);
        results;
    end
endmodule // leadoff_pace_measure_readback_tb_top
